// >>> tkc_pkg.sv
// Shared constants and types for the timekeeper control and status registers.
package tkc_pkg;

	// ==========================================================
	// Register locations on the five-bit host address.
	localparam logic [4:0] ADDR_STATUS = 5'h00;
	localparam logic [4:0] ADDR_LOC1   = 5'h01;
	localparam logic [4:0] ADDR_LOC2   = 5'h02;
	localparam logic [4:0] ADDR_LOC3   = 5'h03;
	localparam logic [4:0] ADDR_LOC4   = 5'h04;
	localparam logic [4:0] ADDR_T0_LSB = 5'h0F;
	localparam logic [4:0] ADDR_T0_MSB = 5'h10;
	localparam logic [4:0] ADDR_T1_LSB = 5'h11;
	localparam logic [4:0] ADDR_T1_MSB = 5'h12;
	localparam logic [4:0] ADDR_TEST   = 5'h1F;
	localparam int         RAM_WORDS   = 31;

	// ==========================================================
	// Bit positions.
	localparam int ST_BLOCK   = 6;
	localparam int ST_PAGE    = 7;
	localparam int TC_RD      = 6;
	localparam int TC_CHG     = 7;
	localparam int RT_DELAY   = 5;
	localparam int RT_SAVE    = 7;
	localparam int PF_OSC     = 6;
	localparam int PF_TEST    = 7;
	localparam int MD_RUN     = 3;
	localparam int MD_SBY_INT = 4;
	localparam int MD_SBY_TMR = 5;
	localparam int IC1_ALARM  = 6;
	localparam int IC1_POWER_FAIL_IN  = 7;
	localparam int IC0_T0     = 6;
	localparam int IC0_T1     = 7;
	localparam logic [1:0] TMR_ONESHOT = 2'h0;
	localparam logic [1:0] TMR_RETRIG  = 2'h3;

	// ==========================================================
	// Reset values.
	localparam logic [7:0] REG_RST     = 8'h00;
	localparam logic [4:0] ST_FLAG_RST = 5'h00;
	localparam logic       SINGLE_RST  = 1'b1;
	localparam logic       OSC_RST     = 1'b1;

	// ==========================================================
	// Timing.
	localparam int CLK_MHZ        = 40;
	localparam int LOCK_LONG_US   = 480;
	localparam int LOCK_SHORT_US  = 30;
	localparam int LOCK_LONG_CYC  = LOCK_LONG_US * CLK_MHZ;
	localparam int LOCK_SHORT_CYC = LOCK_SHORT_US * CLK_MHZ;

	// ==========================================================
	// Carriers.
	typedef struct packed {
		logic       suspend_retrigger_bit;
		logic       rd;
		logic [2:0] clksel;
		logic [1:0] mode;
		logic       run;
	} tkc_tmr_ctl_t;

	typedef struct packed {
		logic [5:0] periodic;
		logic       alarm;
		logic [1:0] tmr_timeout;
		logic       year_end;
		logic       osc_fail;
	} tkc_evt_t;

	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic [4:0] addr;
		logic [7:0] data;
	} tkc_host_t;

	localparam tkc_host_t HOST_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 5'h00, data: 8'h00};

endpackage : tkc_pkg

// >>> tkc_regs.sv
// Host register port, status flags, timer control and mode registers of the timekeeper.
module tkc_regs #(
	parameter int LOCK_LONG_CYC = tkc_pkg::LOCK_LONG_CYC
) (
	input  wire logic               clk_i,
	input  wire logic               srst_i,
	input  wire logic               ce_i,
	input  wire logic               host_cs_n_i,
	input  wire logic               host_rd_n_i,
	input  wire logic               host_wr_n_i,
	input  wire logic [4:0]         host_addr_i,
	input  wire logic [7:0]         host_data_i,
	output logic      [7:0]         host_data_o,
	output logic                    host_data_oe_o,
	input  wire logic               power_fail_in_n_i,
	input  wire logic               backup_supply_low_i,
	input  wire logic               osc_running_i,
	input  wire logic               standby_i,
	input  wire tkc_pkg::tkc_evt_t  evt_i,
	input  wire logic [15:0]        tmr0_count_i,
	input  wire logic [15:0]        tmr1_count_i,
	output logic                    interrupt_out_pin_o,
	output logic                    multi_function_out_pin_o,
	output tkc_pkg::tkc_tmr_ctl_t   tmr0_ctl_o,
	output tkc_pkg::tkc_tmr_ctl_t   tmr1_ctl_o,
	output logic      [1:0]         tmr_retrig_o,
	output logic                    tmr_pins_en_o,
	output logic                    tmr_standby_run_o,
	output logic      [7:0]         clk_mode_o,
	output logic                    leap_feb29_en_o,
	output logic                    single_supply_o,
	output logic                    test_enable_o,
	output logic      [7:0]         test_reg_o,
	output logic                    time_save_track_o,
	output logic                    host_locked_o
);

	// ==========================================================
	// Synchronisers. Address and data are expected to settle before the strobe.
	tkc_pkg::tkc_host_t host_s1_r, host_s2_r;
	logic [2:0]         pin_s1_r, pin_s2_r;
	logic               rd_prev_r, wr_prev_r, pf_prev_r, sby_prev_r;

	// Both stages of host and analog pins.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			host_s1_r <= tkc_pkg::HOST_IDLE;
			host_s2_r <= tkc_pkg::HOST_IDLE;
			pin_s1_r  <= 3'h1;
			pin_s2_r  <= 3'h1;
		end else if (ce_i) begin
			host_s1_r <= '{cs_n: host_cs_n_i, rd_n: host_rd_n_i, wr_n: host_wr_n_i,
				addr: host_addr_i, data: host_data_i};
			host_s2_r <= host_s1_r;
			pin_s1_r  <= {osc_running_i, backup_supply_low_i, power_fail_in_n_i};
			pin_s2_r  <= pin_s1_r;
		end
	end

	logic power_fail_in_n, batt_low, osc_ok, rd_act, wr_act, rd_go, wr_go, pf_fall, sby_entry;
	assign power_fail_in_n  = pin_s2_r[0];
	assign batt_low = pin_s2_r[1];
	assign osc_ok   = pin_s2_r[2];
	assign rd_act   = !host_s2_r.cs_n && !host_s2_r.rd_n;
	assign wr_act   = !host_s2_r.cs_n && !host_s2_r.wr_n;

	// Edge history; an access acts only on the first synchronised cycle of its strobe.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rd_prev_r  <= 1'b0;
			wr_prev_r  <= 1'b0;
			pf_prev_r  <= 1'b1;
			sby_prev_r <= 1'b0;
		end else if (ce_i) begin
			rd_prev_r  <= rd_act;
			wr_prev_r  <= wr_act;
			pf_prev_r  <= power_fail_in_n;
			sby_prev_r <= standby_i;
		end
	end

	assign rd_go     = rd_act && !rd_prev_r && !host_locked_o;
	assign wr_go     = wr_act && !wr_prev_r && !host_locked_o;
	assign pf_fall   = pf_prev_r && !power_fail_in_n;
	assign sby_entry = standby_i && !sby_prev_r;

	// ==========================================================
	// Register state and address decode.
	logic [4:0]              st_flag_r;
	logic                    page_r, block_r;
	tkc_pkg::tkc_tmr_ctl_t   tc_r [2];
	logic [15:0]             hold_r [2];
	logic [15:0]             cnt [2];
	logic [5:0]              per_r;
	logic                    osc_flag_r;
	logic [7:0]              route_r, md_r, icr0_r, icr1_r;
	logic [7:0]              ram [1:tkc_pkg::RAM_WORDS];
	logic [4:0]              a;
	logic [7:0]              wd;
	logic                    p0, st_sel, l1, l2, l3, l4;
	logic [1:0]              w_tc, r_lsb;

	assign cnt[0] = tmr0_count_i;
	assign cnt[1] = tmr1_count_i;
	assign a      = host_s2_r.addr;
	assign wd     = host_s2_r.data;
	assign st_sel = (a == tkc_pkg::ADDR_STATUS);
	assign p0     = !page_r && !st_sel;
	assign l1     = p0 && (a == tkc_pkg::ADDR_LOC1);
	assign l2     = p0 && (a == tkc_pkg::ADDR_LOC2);
	assign l3     = p0 && (a == tkc_pkg::ADDR_LOC3);
	assign l4     = p0 && (a == tkc_pkg::ADDR_LOC4);
	assign w_tc   = {wr_go && l2 && !block_r, wr_go && l1 && !block_r};
	assign r_lsb  = {rd_go && p0 && (a == tkc_pkg::ADDR_T1_LSB), rd_go && p0 && (a == tkc_pkg::ADDR_T0_LSB)};

	// ==========================================================
	// Main status flags; hardware set wins over a host clear in the same cycle.
	logic       tmr_int_ok;
	logic [4:0] st_set, st_clr, pend;
	assign tmr_int_ok = !standby_i || md_r[tkc_pkg::MD_SBY_TMR];
	assign st_set = {evt_i.tmr_timeout[1], evt_i.tmr_timeout[0], evt_i.alarm,
		|(evt_i.periodic & icr0_r[5:0]), 1'b0};
	assign st_clr = (wr_go && st_sel) ? {wd[5:1]} & 5'h1E : 5'h00;
	assign pend = st_flag_r & {icr0_r[tkc_pkg::IC0_T1] && tmr_int_ok, icr0_r[tkc_pkg::IC0_T0] && tmr_int_ok,
		icr1_r[tkc_pkg::IC1_ALARM], 1'b1, icr1_r[tkc_pkg::IC1_POWER_FAIL_IN]};

	// Status flags and selects. The power-fail flag just follows the pin.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_flag_r <= tkc_pkg::ST_FLAG_RST;
			page_r    <= 1'b0;
			block_r   <= 1'b0;
		end else if (ce_i) begin
			st_flag_r[4:1] <= (st_flag_r[4:1] & ~st_clr[4:1]) | st_set[4:1];
			st_flag_r[0]   <= !power_fail_in_n;
			if (wr_go && st_sel) begin
				block_r <= wd[tkc_pkg::ST_BLOCK];
				page_r  <= wd[tkc_pkg::ST_PAGE];
			end
		end
	end

	// Interrupt steering onto the two outputs, registered.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			interrupt_out_pin_o      <= 1'b0;
			multi_function_out_pin_o <= 1'b0;
		end else if (ce_i) begin
			interrupt_out_pin_o      <= |(pend & ~route_r[4:0]);
			multi_function_out_pin_o <= |(pend & route_r[4:0]);
		end
	end

	// ==========================================================
	// Timer control. A written one in the read bit snapshots the count into the hold register.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			for (int i = 0; i < 2; i++) begin
				tc_r[i]   <= tkc_pkg::REG_RST;
				hold_r[i] <= 16'h0000;
			end
			tmr_retrig_o <= 2'h0;
		end else if (ce_i) begin
			for (int i = 0; i < 2; i++) begin
				tmr_retrig_o[i] <= w_tc[i] && wd[tkc_pkg::TC_CHG] && (wd[2:1] == tkc_pkg::TMR_RETRIG);
				if (w_tc[i]) begin
					tc_r[i] <= wd;
					if (wd[tkc_pkg::TC_RD])
						hold_r[i] <= cnt[i];
				end
				if (r_lsb[i])
					tc_r[i].rd <= 1'b0;
				if (evt_i.tmr_timeout[i] && (tc_r[i].mode == tkc_pkg::TMR_ONESHOT))
					tc_r[i].run <= 1'b0;
			end
		end
	end

	assign tmr0_ctl_o = tc_r[0];
	assign tmr1_ctl_o = tc_r[1];

	// Standby handling of the timers and their pins.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tmr_pins_en_o     <= 1'b1;
			tmr_standby_run_o <= 1'b1;
		end else if (ce_i) begin
			tmr_pins_en_o     <= !standby_i;
			tmr_standby_run_o <= !standby_i || md_r[tkc_pkg::MD_SBY_TMR];
		end
	end

	// ==========================================================
	// Periodic flags, oscillator-fail flag, supply mode and test enable.
	logic per_rd;
	assign per_rd = rd_go && l3 && !block_r;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			per_r           <= 6'h00;
			osc_flag_r      <= tkc_pkg::OSC_RST;
			single_supply_o <= tkc_pkg::SINGLE_RST;
			test_enable_o   <= 1'b0;
		end else if (ce_i) begin
			per_r <= (per_rd ? 6'h00 : per_r) | evt_i.periodic;
			if (wr_go && l3 && !block_r) begin
				single_supply_o <= wd[tkc_pkg::PF_OSC];
				test_enable_o   <= wd[tkc_pkg::PF_TEST];
			end
			if (wr_go && l1 && block_r && wd[tkc_pkg::MD_RUN] && osc_ok)
				osc_flag_r <= 1'b0;
			if (evt_i.osc_fail) begin
				osc_flag_r      <= 1'b1;
				single_supply_o <= 1'b1;
			end
		end
	end

	// Test register; only reachable while test mode is enabled.
	always_ff @(posedge clk_i) begin
		if (srst_i)
			test_reg_o <= tkc_pkg::REG_RST;
		else if (ce_i && wr_go && p0 && test_enable_o && (a == tkc_pkg::ADDR_TEST))
			test_reg_o <= wd;
	end

	// ==========================================================
	// Routing register. Power failure freezes the time-save copy, overriding a write.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			route_r <= tkc_pkg::REG_RST;
		end else if (ce_i) begin
			if (wr_go && l4 && !block_r)
				route_r <= wd & 8'hBF;
			if (pf_fall)
				route_r[tkc_pkg::RT_SAVE] <= 1'b0;
		end
	end

	assign time_save_track_o = route_r[tkc_pkg::RT_SAVE];

	// ==========================================================
	// Mode register and interrupt enables.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			md_r <= tkc_pkg::REG_RST;
		end else if (ce_i) begin
			if (wr_go && l1 && block_r) begin
				md_r <= wd;
				md_r[tkc_pkg::MD_RUN] <= wd[tkc_pkg::MD_RUN] && osc_ok;
			end else if (evt_i.year_end) begin
				md_r[1:0] <= md_r[1:0] + 2'h1;
			end
			if (evt_i.osc_fail)
				md_r[tkc_pkg::MD_RUN] <= 1'b0;
		end
	end

	assign clk_mode_o = md_r;

	// Leap day permission, registered.
	always_ff @(posedge clk_i) begin
		if (srst_i)
			leap_feb29_en_o <= 1'b1;
		else if (ce_i)
			leap_feb29_en_o <= (md_r[1:0] == 2'h0);
	end

	// Interrupt enables; entering standby without interrupt retention wipes them.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			icr0_r <= tkc_pkg::REG_RST;
			icr1_r <= tkc_pkg::REG_RST;
		end else if (ce_i) begin
			if (wr_go && l3 && block_r)
				icr0_r <= wd;
			if (wr_go && l4 && block_r)
				icr1_r <= wd;
			if (sby_entry && !md_r[tkc_pkg::MD_SBY_INT]) begin
				icr0_r      <= 8'h00;
				icr1_r[7:6] <= 2'h0;
			end
		end
	end

	// ==========================================================
	// General RAM of the second page; no reset, like the storage it models.
	always_ff @(posedge clk_i) begin
		if (ce_i && wr_go && page_r && !st_sel)
			ram[a] <= wd;
	end

	// ==========================================================
	// Host lockout after power failure.
	typedef enum logic [1:0] {LK_IDLE, LK_WAIT, LK_LOCKED} tkc_lock_t;
	tkc_lock_t   lk_r;
	logic [15:0] lk_cnt_r;
	logic        lk_long_r;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			lk_r          <= LK_IDLE;
			lk_cnt_r      <= 16'h0000;
			lk_long_r     <= 1'b0;
			host_locked_o <= 1'b0;
		end else if (ce_i) begin
			case (lk_r)
				LK_IDLE: begin
					lk_cnt_r <= 16'h0000;
					if (pf_fall) begin
						lk_r      <= LK_WAIT;
						lk_long_r <= route_r[tkc_pkg::RT_DELAY];
					end
				end
				LK_WAIT: begin
					lk_cnt_r <= lk_cnt_r + 16'h0001;
					if (power_fail_in_n) begin
						lk_r <= LK_IDLE;
					end else if ((lk_long_r && (!route_r[tkc_pkg::RT_DELAY]
						|| lk_cnt_r == 16'(LOCK_LONG_CYC - 1)))
						|| (!lk_long_r && lk_cnt_r == 16'(tkc_pkg::LOCK_SHORT_CYC - 1))) begin
						lk_r          <= LK_LOCKED;
						host_locked_o <= 1'b1;
					end
				end
				LK_LOCKED: begin
					if (power_fail_in_n) begin
						lk_r          <= LK_IDLE;
						host_locked_o <= 1'b0;
					end
				end
				default: begin
					lk_r          <= LK_IDLE;
					host_locked_o <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Read path. Data is captured once at the strobe start and held for the host.
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		if (st_sel)
			rd_mux = {page_r, block_r, st_flag_r, interrupt_out_pin_o || multi_function_out_pin_o};
		else if (page_r)
			rd_mux = ram[a];
		else begin
			case (a)
				tkc_pkg::ADDR_LOC1:   rd_mux = block_r ? md_r : tc_r[0];
				tkc_pkg::ADDR_LOC2:   rd_mux = block_r ? 8'h00 : tc_r[1];
				tkc_pkg::ADDR_LOC3:   rd_mux = block_r ? icr0_r : {test_enable_o, osc_flag_r, per_r};
				tkc_pkg::ADDR_LOC4:   rd_mux = block_r ? icr1_r : {route_r[7],
					batt_low && icr1_r[tkc_pkg::IC1_POWER_FAIL_IN], route_r[5:0]};
				tkc_pkg::ADDR_T0_LSB: rd_mux = hold_r[0][7:0];
				tkc_pkg::ADDR_T0_MSB: rd_mux = hold_r[0][15:8];
				tkc_pkg::ADDR_T1_LSB: rd_mux = hold_r[1][7:0];
				tkc_pkg::ADDR_T1_MSB: rd_mux = hold_r[1][15:8];
				tkc_pkg::ADDR_TEST:   rd_mux = test_enable_o ? test_reg_o : 8'h00;
				default:              rd_mux = 8'h00;
			endcase
		end
	end

	// Output data and its enable.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			host_data_o    <= 8'h00;
			host_data_oe_o <= 1'b0;
		end else if (ce_i) begin
			if (rd_go)
				host_data_o <= rd_mux;
			host_data_oe_o <= rd_act && !host_locked_o;
		end
	end

	// ==========================================================
	// Checks.
	chk_power_fail_in_follow: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i |=> (st_flag_r[0] == !$past(power_fail_in_n))) else $error("power-fail flag does not track pin");
	chk_irq_cause: assert property (@(posedge clk_i) disable iff (srst_i)
		(interrupt_out_pin_o || multi_function_out_pin_o) |-> $past(st_flag_r != 5'h00))
		else $error("interrupt output without status flag");
	chk_set_wins: assert property (@(posedge clk_i) disable iff (srst_i)
		(ce_i && evt_i.alarm) |=> st_flag_r[2]) else $error("alarm event lost");
	chk_per_clear: assert property (@(posedge clk_i) disable iff (srst_i)
		(ce_i && per_rd && evt_i.periodic == 6'h00) |=> (per_r == 6'h00)) else $error("periodic flags not cleared");
	chk_osc_fail: assert property (@(posedge clk_i) disable iff (srst_i)
		(ce_i && evt_i.osc_fail) |=> (osc_flag_r && single_supply_o && !md_r[tkc_pkg::MD_RUN]))
		else $error("oscillator failure not applied");
	chk_oneshot_stop: assert property (@(posedge clk_i) disable iff (srst_i)
		(ce_i && evt_i.tmr_timeout[0] && tc_r[0].mode == tkc_pkg::TMR_ONESHOT) |=> !tc_r[0].run)
		else $error("mode 0 timer kept running");
	chk_short_lock: assert property (@(posedge clk_i) disable iff (srst_i)
		(ce_i && lk_r == LK_WAIT && !lk_long_r && !power_fail_in_n && lk_cnt_r == 16'(tkc_pkg::LOCK_SHORT_CYC - 1))
		|=> host_locked_o) else $error("short lockout late");
	chk_sby_clear: assert property (@(posedge clk_i) disable iff (srst_i)
		(ce_i && sby_entry && !md_r[tkc_pkg::MD_SBY_INT]) |=> (icr0_r == 8'h00 && icr1_r[7:6] == 2'h0))
		else $error("standby entry kept enables");
	chk_save_freeze: assert property (@(posedge clk_i) disable iff (srst_i)
		(ce_i && pf_fall) |=> !time_save_track_o) else $error("time-save not frozen");
	chk_retrig_mode: assert property (@(posedge clk_i) disable iff (srst_i)
		tmr_retrig_o[0] |-> (tc_r[0].mode == tkc_pkg::TMR_RETRIG)) else $error("retrigger outside mode 3");

endmodule : tkc_regs

// >>> tkc_host_model.sv
// Host processor model that runs strobed register cycles on the timekeeper port.
module tkc_host_model (
	input  wire logic          clk_i,
	output tkc_pkg::tkc_host_t bus_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Idle bus at time zero.
	initial begin
		bus_o = tkc_pkg::HOST_IDLE;
	end

	// ==========================================================
	// One access: address settles two cycles before the strobe, strobe stays low four cycles.
	// A released data bus shows the inverse of its last byte so a stale value never passes.
	task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus_o.addr <= a;
		bus_o.data <= wr ? d : ~bus_o.data;
		repeat (2) @(posedge clk_i);
		bus_o.cs_n <= 1'b0;
		bus_o.rd_n <= wr;
		bus_o.wr_n <= !wr;
		repeat (4) @(posedge clk_i);
		bus_o.cs_n <= 1'b1;
		bus_o.rd_n <= 1'b1;
		bus_o.wr_n <= 1'b1;
		bus_o.data <= ~bus_o.data;
		repeat (4) @(posedge clk_i);
	endtask : acc
endmodule : tkc_host_model

// >>> tb_tkc_regs.sv
// Self-checking bench for the timekeeper control and status registers.
module tb_tkc_regs;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {string n; logic [7:0] v;} tkc_note_t;
	logic clk_i = 1'b0, srst_i = 1'b1, pf_n = 1'b1, batt = 1'b0, sby = 1'b0, oe_q = 1'b0;
	logic [7:0] dout, mode, treg;
	logic oe, interrupt_out_pin, multi_function_out_pin, pins, srun, feb, single, ten, save, lock;
	logic [1:0] retrig;
	logic [15:0] cnt0 = 16'h0000;
	tkc_pkg::tkc_evt_t evt = '0;
	tkc_pkg::tkc_tmr_ctl_t c0, c1;
	tkc_pkg::tkc_host_t bus;
	tkc_note_t q[$];
	tkc_note_t nt;
	int failures = 0, comparisons = 0, cyc = 0, rt_cnt = 0;

	tkc_host_model host (.clk_i(clk_i), .bus_o(bus));
	tkc_regs #(.LOCK_LONG_CYC(40)) uut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .host_cs_n_i(bus.cs_n),
		.host_rd_n_i(bus.rd_n), .host_wr_n_i(bus.wr_n), .host_addr_i(bus.addr), .host_data_i(bus.data),
		.host_data_o(dout), .host_data_oe_o(oe), .power_fail_in_n_i(pf_n), .backup_supply_low_i(batt),
		.osc_running_i(1'b1), .standby_i(sby), .evt_i(evt), .tmr0_count_i(cnt0), .tmr1_count_i(16'h0000),
		.interrupt_out_pin_o(interrupt_out_pin), .multi_function_out_pin_o(multi_function_out_pin), .tmr0_ctl_o(c0), .tmr1_ctl_o(c1),
		.tmr_retrig_o(retrig), .tmr_pins_en_o(pins), .tmr_standby_run_o(srun), .clk_mode_o(mode),
		.leap_feb29_en_o(feb), .single_supply_o(single), .test_enable_o(ten), .test_reg_o(treg),
		.time_save_track_o(save), .host_locked_o(lock));

	// ==========================================================
	// Clock at 40 MHz.
	always #12.5 clk_i = ~clk_i;

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic results();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		host.acc(1'b1, a, d);
	endtask : wr

	// A read notes its expectation first; the watcher takes it when read data appears.
	task automatic rd(input string n, input logic [4:0] a, input logic [7:0] e);
		q.push_back('{n, e});
		host.acc(1'b0, a, 8'h00);
	endtask : rd

	task automatic pulse(input logic [10:0] v);
		@(posedge clk_i);
		evt <= tkc_pkg::tkc_evt_t'(v);
		@(posedge clk_i);
		evt <= '0;
	endtask : pulse

	// ==========================================================
	// Watcher: compares each read result once, counts retrigger pulses, and cuts a hang short.
	always @(posedge clk_i) begin
		oe_q <= oe;
		cyc <= cyc + 1;
		if (retrig[0] === 1'b1) rt_cnt <= rt_cnt + 1;
		if (oe === 1'b1 && oe_q !== 1'b1) begin
			if (q.size() == 0) chk("unasked read", 8'h01, 8'h00);
			else begin
				nt = q.pop_front();
				chk(nt.n, dout, nt.v);
			end
		end
		if (cyc == 20000) begin
			failures++;
			results();
		end
	end

	// ==========================================================
	// Main sequence.
	initial begin
		logic [7:0] r;
		logic [15:0] c;
		void'($urandom(32'hfebd6376));
		repeat (8) @(posedge clk_i);
		srst_i <= 1'b0;
		@(negedge clk_i);
		chk("single supply", single, 1'b1);
		rd("periodic", 5'h03, 8'h40);
		wr(5'h00, 8'h40);
		for (int k = 0; k < 4; k++) begin
			r = {k[1:0], 6'($urandom)} | 8'h08;
			wr(5'h01, r);
			rd("mode", 5'h01, r);
			chk("mode out", mode, r);
			chk("leap", feb, r[1:0] == 2'h0);
		end
		// Standby with interrupts not kept clears the alarm enable and locks the timer pins.
		wr(5'h01, 8'h08);
		wr(5'h04, 8'h40);
		sby <= 1'b1;
		repeat (3) @(negedge clk_i);
		chk("pins", pins, 1'b0);
		chk("standby run", srun, 1'b0);
		@(posedge clk_i);
		sby <= 1'b0;
		rd("icr1", 5'h04, 8'h00);
		wr(5'h00, 8'h00);
		rd("osc flag", 5'h03, 8'h00);
		r = 8'($urandom_range(63, 1));
		pulse({r[5:0], 5'h00});
		rd("periodic", 5'h03, r);
		rd("periodic", 5'h03, 8'h00);
		pulse(11'h01C);
		rd("status", 5'h00, 8'h38);
		rd("status", 5'h00, 8'h38);
		wr(5'h00, 8'h08);
		rd("status", 5'h00, 8'h30);
		wr(5'h00, 8'h30);
		// Alarm routed to the second pin.
		wr(5'h04, 8'h04);
		wr(5'h00, 8'h40);
		wr(5'h04, 8'h40);
		pulse(11'h010);
		// The flag lands at the end of the pulse and the pin one cycle later.
		repeat (2) @(negedge clk_i);
		chk("mfo", multi_function_out_pin, 1'b1);
		chk("interrupt_out_pin", interrupt_out_pin, 1'b0);
		rd("status", 5'h00, 8'h49);
		wr(5'h00, 8'h48);
		rd("status", 5'h00, 8'h40);
		chk("mfo", multi_function_out_pin, 1'b0);
		// Timer snapshot and retrigger, then a mode-0 time-out.
		wr(5'h00, 8'h00);
		c = 16'($urandom);
		cnt0 <= c;
		wr(5'h01, 8'hC7);
		cnt0 <= ~c;
		chk("retrigger", 8'(rt_cnt), 8'h01);
		chk("run", c0.run, 1'b1);
		rd("tmr ctl", 5'h01, 8'hC7);
		rd("tmr lsb", 5'h0F, c[7:0]);
		rd("tmr ctl", 5'h01, 8'h87);
		rd("tmr msb", 5'h10, c[15:8]);
		wr(5'h01, 8'h01);
		pulse(11'h004);
		rd("tmr ctl", 5'h01, 8'h00);
		wr(5'h00, 8'h10);
		// Power fail with delayed lockout.
		batt <= 1'b1;
		wr(5'h04, 8'hA0);
		pf_n <= 1'b0;
		repeat (6) @(negedge clk_i);
		chk("time save", save, 1'b0);
		rd("status", 5'h00, 8'h02);
		repeat (40) @(negedge clk_i);
		chk("locked", lock, 1'b1);
		host.acc(1'b0, 5'h00, 8'h00);
		@(posedge clk_i);
		pf_n <= 1'b1;
		repeat (6) @(negedge clk_i);
		chk("locked", lock, 1'b0);
		rd("status", 5'h00, 8'h00);
		rd("routing", 5'h04, 8'h20);
		// Test register only while enabled.
		rd("test", 5'h1F, 8'h00);
		wr(5'h03, 8'h80);
		wr(5'h1F, 8'h5A);
		rd("test", 5'h1F, 8'h5A);
		chk("single supply", single, 1'b0);
		wr(5'h1F, 8'h00);
		wr(5'h03, 8'h00);
		// Oscillator failure raises the flag again and stops the clock chain.
		pulse(11'h001);
		rd("osc flag", 5'h03, 8'h40);
		chk("mode stop", mode, 8'h00);
		// Power fail without the delay bit locks after the short wait.
		wr(5'h04, 8'h00);
		pf_n <= 1'b0;
		repeat (1100) @(negedge clk_i);
		chk("locked early", lock, 1'b0);
		repeat (110) @(negedge clk_i);
		chk("locked short", lock, 1'b1);
		@(posedge clk_i);
		pf_n <= 1'b1;
		chk("pending reads", 8'(q.size()), 8'h00);
		results();
	end
endmodule : tb_tkc_regs
